// ===== verification/rpc_host_model.sv
// rpc_host_model: axi4-lite master standing in for the host processor.
// assumes: one clock; the bench calls wr and rd, one transfer at a time.
`timescale 1ns/10ps
`default_nettype none
module rpc_host_model (
    input wire logic sys_clk,
    output var logic [7:0] s_awaddr,
    output var logic s_awvalid,
    input wire logic s_awready,
    output var logic [31:0] s_wdata,
    output var logic [3:0] s_wstrb,
    output var logic s_wvalid,
    input wire logic s_wready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    output var logic s_bready,
    output var logic [7:0] s_araddr,
    output var logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    output var logic s_rready
);
    ////////////////////////////////////////////////////////////////////////
    // idle bus from time zero
    initial
    begin
        {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
        {s_araddr, s_arvalid, s_rready} = '0;
    end
    // one write; bready is raised zero to two cycles after the request
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
        int stall;
        stall = $urandom_range(2, 0);
        @(posedge sys_clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= s;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= (stall == 0);
        @(posedge sys_clk);
        while (!(s_bvalid && s_bready))
        begin
            if (s_awvalid && s_awready) {s_awvalid, s_awaddr} <= {1'b0, ~a}; // released address scrambled
            if (s_wvalid && s_wready) {s_wvalid, s_wdata} <= {1'b0, ~d};
            stall = stall - 1;
            if (stall <= 0) s_bready <= 1'b1;
            @(posedge sys_clk);
        end
        resp = s_bresp;
        s_bready <= 1'b0;
    endtask
    // one read; the bench watches the data
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        @(posedge sys_clk);
        while (!(s_rvalid && s_rready))
        begin
            if (s_arvalid && s_arready) {s_arvalid, s_araddr} <= {1'b0, ~a};
            @(posedge sys_clk);
        end
        s_rready <= 1'b0;
    endtask
endmodule // rpc_host_model
`default_nettype wire

// ===== verification/tb_ram_pointer_and_config_regs.sv
// tb_ram_pointer_and_config_regs: self-checking bench of the register bank.
// assumes: rpc_host_model drives the bus; sideband requests driven here.
`timescale 1ns/10ps
`default_nettype none
module tb_ram_pointer_and_config_regs;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, resp;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic bufferAccess = 1'b0, backplaneMode = 1'b0;
    logic txDriveReq = 1'b0, pulseAReq = 1'b0, pulseBReq = 1'b0;
    logic [10:0] ramAddr;
    logic [2:0] indirectSelect;
    logic readDirection, selectReserved, softReset, chainingEnable;
    logic driverEnable_n, linePulseA_n, linePulseB_n;
    logic [33:0] expQ[$];
    logic [33:0] seen;
    int n_mismatch = 0;
    int n_checks = 0;
    wire logic [20:0] outs = {ramAddr, readDirection, indirectSelect, selectReserved, softReset,
        chainingEnable, driverEnable_n, linePulseA_n, linePulseB_n};
    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    rpc_regs_top dut (.sys_clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .bufferAccess, .backplaneMode, .txDriveReq,
        .pulseAReq, .pulseBReq, .ramAddr, .readDirection, .indirectSelect, .selectReserved,
        .softReset, .chainingEnable, .driverEnable_n, .linePulseA_n, .linePulseB_n);
    rpc_host_model host (.sys_clk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rvalid, .s_rready);
    ////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    // expected outputs with the drivers idle
    function automatic logic [20:0] ex(input logic [10:0] p, input logic d, input logic [2:0] s,
        input logic r, input logic c);
        return {p, d, s, s > 3'h4, r, c, 3'b111};
    endfunction
    task automatic wrx(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1,
        input logic [1:0] r = rpc_pkg::RESP_OKAY);
        host.wr(a, d, s, resp);
        chk("bresp", r, resp);
        #1;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = rpc_pkg::RESP_OKAY);
        expQ.push_back({r, d});
        host.rd(a);
    endtask
    // n back-to-back buffer accesses
    task automatic acc(input int n);
        @(posedge sys_clk);
        bufferAccess <= 1'b1;
        repeat (n) @(posedge sys_clk);
        bufferAccess <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // read monitor takes the oldest note at each read handshake
    always @(posedge sys_clk)
    begin
        if (rst_n && s_rvalid && s_rready)
        begin
            seen = (expQ.size() > 0) ? expQ.pop_front() : 'x;
            chk("read", seen, {s_rresp, s_rdata});
        end
    end
    // watchdog
    initial
    begin
        #100000;
        n_mismatch++;
        report_and_stop;
    end
    // main sequence
    initial
    begin
        void'($urandom(12));
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk("outs", ex(11'h000, 0, 0, 0, 0), outs);
        for (int i = 0; i < 4; i++) rdx(8'(4 * i), 32'h0000_0000);
        $display("test reset done");
        wrx(rpc_pkg::OFF_PTR_HIGH, 32'h0000_00C5);
        wrx(rpc_pkg::OFF_PTR_LOW, 32'h0000_00FE);
        chk("outs", ex(11'h5FE, 1, 0, 0, 0), outs);
        rdx(rpc_pkg::OFF_PTR_HIGH, 32'h0000_00C5);
        acc(3);
        chk("outs", ex(11'h601, 1, 0, 0, 0), outs);
        wrx(rpc_pkg::OFF_PTR_HIGH, 32'h0000_0047);
        wrx(rpc_pkg::OFF_PTR_LOW, 32'h0000_00FF);
        acc(1);
        chk("outs", ex(11'h000, 0, 0, 0, 0), outs);
        wrx(rpc_pkg::OFF_PTR_HIGH, 32'h0000_0005);
        acc(2);
        chk("outs", ex(11'h500, 0, 0, 0, 0), outs);
        $display("test pointer done");
        for (int i = 0; i < 8; i++)
        begin
            wrx(rpc_pkg::OFF_IND_SEL, 32'(i));
            chk("outs", ex(11'h500, 0, 3'(i), 0, 0), outs);
            rdx(rpc_pkg::OFF_CONFIG, 32'(i % 4));
            rdx(rpc_pkg::OFF_IND_SEL, 32'(i));
        end
        wrx(rpc_pkg::OFF_CONFIG, 32'h0000_0062);
        chk("outs", ex(11'h500, 0, 3'h2, 0, 1), outs);
        rdx(rpc_pkg::OFF_IND_SEL, 32'h0000_0002);
        $display("test select done");
        wrx(rpc_pkg::OFF_CONFIG, 32'h0000_00E2);
        chk("outs", ex(11'h500, 0, 3'h2, 1, 1), outs);
        rdx(rpc_pkg::OFF_CONFIG, 32'h0000_00E2);
        rdx(rpc_pkg::OFF_PTR_HIGH, 32'h0000_0005);
        wrx(rpc_pkg::OFF_CONFIG, 32'h0000_0062);
        chk("outs", ex(11'h500, 0, 3'h2, 0, 1), outs);
        $display("test soft reset done");
        for (int t = 0; t < 2; t++)
        begin
            wrx(rpc_pkg::OFF_CONFIG, t ? 32'h0000_0020 : 32'h0000_0000);
            for (int k = 0; k < 12; k++)
            begin
                @(posedge sys_clk);
                {backplaneMode, txDriveReq, pulseAReq, pulseBReq} <= 4'($urandom);
                repeat (2) @(posedge sys_clk);
                #1 chk("drivers", {~(t[0] & txDriveReq), ~(t[0] & pulseAReq),
                    ~((t[0] | backplaneMode) & pulseBReq)}, outs[2:0]);
            end
            @(posedge sys_clk);
            {backplaneMode, txDriveReq, pulseAReq, pulseBReq} <= 4'h0;
        end
        $display("test drivers done");
        wrx(8'h10, 32'h0000_00FF, 4'h1, rpc_pkg::RESP_SLVERR);
        rdx(8'h10, 32'h0000_0000, rpc_pkg::RESP_SLVERR);
        wrx(rpc_pkg::OFF_PTR_LOW, 32'h0000_00AA, 4'h0);
        rdx(rpc_pkg::OFF_PTR_LOW, 32'h0000_0000);
        $display("test errors done");
        @(posedge sys_clk);
        #1 chk("pending", 0, expQ.size());
        report_and_stop;
    end
endmodule // tb_ram_pointer_and_config_regs
`default_nettype wire

// ===== verilog/rpc_axil_slave.sv
// rpc_axil_slave: AXI4-Lite slave front end turning bus beats into strobes.
// assumes: single outstanding write and read; only byte lane 0 is stored.
`timescale 1ns/10ps
`default_nettype none
module rpc_axil_slave (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    rpc_reg_if.bus regs
);
    logic awHave, wHave, wLane;
    logic [7:0] awAddr, wData;
    logic next_awHave, next_wHave, next_wLane;
    logic [7:0] next_awAddr, next_wData;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic commit;

    // a write commits once address and data are both held
    assign commit = awHave && wHave && !s_bvalid;
    assign regs.wrEn = commit && wLane;
    assign regs.wrAddr = awAddr;
    assign regs.wrData = wData;
    assign regs.rdAddr = s_araddr;

    // channel bookkeeping
    always_comb
    begin
        next_awHave = awHave;
        next_awAddr = awAddr;
        next_wHave = wHave;
        next_wData = wData;
        next_wLane = wLane;
        next_bvalid = s_bvalid;
        next_bresp = s_bresp;
        next_rvalid = s_rvalid;
        next_rdata = s_rdata;
        next_rresp = s_rresp;
        if (s_awvalid && s_awready)
        begin
            next_awHave = 1'b1;
            next_awAddr = s_awaddr;
        end
        if (s_wvalid && s_wready)
        begin
            next_wHave = 1'b1;
            next_wData = s_wdata[7:0];
            next_wLane = s_wstrb[0];
        end
        if (s_bvalid && s_bready)
            next_bvalid = 1'b0;
        if (commit)
        begin
            next_awHave = 1'b0;
            next_wHave = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = regs.wrErr ? rpc_pkg::RESP_SLVERR : rpc_pkg::RESP_OKAY;
        end
        if (s_rvalid && s_rready)
            next_rvalid = 1'b0;
        if (s_arvalid && s_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata = {24'h00_0000, regs.read_direction};
            next_rresp = regs.rdErr ? rpc_pkg::RESP_SLVERR : rpc_pkg::RESP_OKAY;
        end
        next_awready = !next_awHave && !next_bvalid;
        next_wready = !next_wHave && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // state registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            awHave <= 1'b0;
            awAddr <= 8'h00;
            wHave <= 1'b0;
            wData <= 8'h00;
            wLane <= 1'b0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= rpc_pkg::RESP_OKAY;
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= rpc_pkg::RESP_OKAY;
        end
        else
        begin
            awHave <= next_awHave;
            awAddr <= next_awAddr;
            wHave <= next_wHave;
            wData <= next_wData;
            wLane <= next_wLane;
            s_awready <= next_awready;
            s_wready <= next_wready;
            s_bvalid <= next_bvalid;
            s_bresp <= next_bresp;
            s_arready <= next_arready;
            s_rvalid <= next_rvalid;
            s_rdata <= next_rdata;
            s_rresp <= next_rresp;
        end
    end
endmodule // rpc_axil_slave
`default_nettype wire

// ===== verilog/rpc_pkg.sv
// rpc_pkg: offsets, field positions, reset values and codes of the
// buffer pointer and configuration register bank.
// assumes: byte registers in the low lane of a 32-bit AXI4-Lite word.
`default_nettype none
package rpc_pkg;
    // bus, register, pointer and select widths
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int REG_W = 8;
    localparam int PTR_W = 11;
    localparam int SEL_W = 3;
    // register byte offsets
    localparam logic [7:0] OFF_PTR_HIGH = 8'h00;
    localparam logic [7:0] OFF_PTR_LOW = 8'h04;
    localparam logic [7:0] OFF_IND_SEL = 8'h08;
    localparam logic [7:0] OFF_CONFIG = 8'h0C;
    // pointer high fields
    localparam int PH_READ_DIR = 7;
    localparam int PH_AUTO = 6;
    localparam int PH_UPPER_MSB = 2;
    // indirect select fields
    localparam int SEL_TOP = 2;
    localparam int SEL_LOW_MSB = 1;
    // configuration fields
    localparam int CFG_SW_RESET = 7;
    localparam int CFG_CHAIN = 6;
    localparam int CFG_TX_ENABLE = 5;
    // reset values, pointer step and pointer top
    localparam logic [PTR_W-1:0] RST_PTR = 11'h000;
    localparam logic [SEL_W-1:0] RST_SEL = 3'h0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic [PTR_W-1:0] PTR_STEP = 11'h001;
    localparam logic [PTR_W-1:0] PTR_TOP = 11'h7FF;
    // indirect register codes; above setup 2 is reserved
    typedef enum logic [SEL_W-1:0] {
        IND_TENTATIVE_ID = 3'h0,
        IND_NODE_ID = 3'h1,
        IND_SETUP1 = 3'h2,
        IND_NEXT_ID = 3'h3,
        IND_SETUP2 = 3'h4
    } rpc_indirect_e;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== verilog/rpc_pointer.sv
// rpc_pointer: 11-bit buffer pointer with byte loads and auto advance.
// assumes: load and advance strobes come from logic on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module rpc_pointer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic loadUpper,
    input wire logic loadLower,
    input wire logic [7:0] loadData,
    input wire logic advance,
    output logic [10:0] pointer
);
    logic [10:0] next_pointer;

    // advance wraps at the top; a host load overrides the step in the bits it loads
    always_comb
    begin
        next_pointer = pointer;
        if (advance)
            next_pointer = pointer + rpc_pkg::PTR_STEP; // R2 R17
        if (loadUpper)
            next_pointer[10:8] = loadData[rpc_pkg::PH_UPPER_MSB:0]; // R3
        if (loadLower)
            next_pointer[7:0] = loadData; // R4
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pointer <= rpc_pkg::RST_PTR;
        else
            pointer <= next_pointer;
    end
endmodule // rpc_pointer
`default_nettype wire

// ===== verilog/rpc_reg_if.sv
// rpc_reg_if: register access strobes between bus slave and register bank.
// assumes: one clock; write strobe is a single-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
interface rpc_reg_if;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic wrErr;
    logic [7:0] rdAddr;
    logic [7:0] read_direction;
    logic rdErr;
    modport bus (output wrEn, wrAddr, wrData, rdAddr, input wrErr, read_direction, rdErr);
    modport regs (input wrEn, wrAddr, wrData, rdAddr, output wrErr, read_direction, rdErr);
endinterface
`default_nettype wire

// ===== verilog/rpc_regs_top.sv
// rpc_regs_top: buffer pointer, indirect select and upper configuration
// bits of a token-passing network controller, behind AXI4-Lite.
// assumes: transmit requests and buffer access strobes come from engines
// on sys_clk; status, next-id and diagnostic registers live elsewhere and
// watch softReset.
//
// Behaviour
// (R1) pointer high bit 7 sets access direction
// (R2) bit 6 advances pointer after each access
// (R3) pointer high bits 2-0 give upper address
// (R4) pointer low gives lower eight address bits
// (R5) sub-address picks indirect register, 101-111 reserved
// (R6) low select bits shared with configuration
// (R7) configuration write clears top select bit
// (R8) configuration bit 7 holds software reset
// (R9) software reset keeps configuration and mode
// (R10) software reset hits only status, next-id, diagnostics
// (R11) host clears bit 7 to end reset
// (R12) configuration bit 6 enables command chaining
// (R13) transmit enable low keeps drivers inactive; pulse b still free in backplane mode
// (R14) transmit enable high lets drivers pulse
// (R15) transmit enable resets to zero
// (R16) host sets transmit enable after node id
// (R17) auto advance wraps top address to zero
// (R18) host writes zeros to reserved bits
`timescale 1ns/10ps
`default_nettype none
module rpc_regs_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic bufferAccess,
    input wire logic backplaneMode,
    input wire logic txDriveReq,
    input wire logic pulseAReq,
    input wire logic pulseBReq,
    output logic [10:0] ramAddr,
    output logic readDirection,
    output logic [2:0] indirectSelect,
    output logic selectReserved,
    output logic softReset,
    output logic chainingEnable,
    output logic driverEnable_n,
    output logic linePulseA_n,
    output logic linePulseB_n
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    rpc_reg_if regBus ();
    logic autoAdvance;
    logic transmitEnableBit;
    logic wrHigh;
    logic wrLow;
    logic wrSel;
    logic wrCfg;
    logic advance;
    logic next_readDirection;
    logic next_autoAdvance;
    logic next_selTop;
    logic [1:0] next_selLow;
    logic next_softReset;
    logic next_chaining;
    logic next_txEnBit;
    logic next_selectReserved;
    logic next_driverEnable_n;
    logic next_linePulseA_n;
    logic next_linePulseB_n;

    ////////////////////////////////////////////////////////////////////////
    // bus front end
    rpc_axil_slave slave (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .regs(regBus)
    );

    // write decode per register
    assign wrHigh = regBus.wrEn && (regBus.wrAddr == rpc_pkg::OFF_PTR_HIGH);
    assign wrLow = regBus.wrEn && (regBus.wrAddr == rpc_pkg::OFF_PTR_LOW);
    assign wrSel = regBus.wrEn && (regBus.wrAddr == rpc_pkg::OFF_IND_SEL);
    assign wrCfg = regBus.wrEn && (regBus.wrAddr == rpc_pkg::OFF_CONFIG);

    // unmapped write address answers with an error
    always_comb
    begin
        case (regBus.wrAddr)
            rpc_pkg::OFF_PTR_HIGH,
            rpc_pkg::OFF_PTR_LOW,
            rpc_pkg::OFF_IND_SEL,
            rpc_pkg::OFF_CONFIG: regBus.wrErr = 1'b0;
            default: regBus.wrErr = 1'b1;
        endcase
    end

    // read mux; reserved bits read as zero
    // config bits 4:2 are kept by another block
    always_comb
    begin
        regBus.read_direction = 8'h00;
        regBus.rdErr = 1'b0;
        case (regBus.rdAddr)
            rpc_pkg::OFF_PTR_HIGH: regBus.read_direction = {readDirection, autoAdvance, 3'h0, ramAddr[10:8]};
            rpc_pkg::OFF_PTR_LOW: regBus.read_direction = ramAddr[7:0];
            rpc_pkg::OFF_IND_SEL: regBus.read_direction = {5'h00, indirectSelect};
            rpc_pkg::OFF_CONFIG: regBus.read_direction = {softReset, chainingEnable, transmitEnableBit,
                3'h0, indirectSelect[rpc_pkg::SEL_LOW_MSB:0]};
            default: regBus.rdErr = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer pointer
    // only an engine access with auto advance set steps it
    assign advance = bufferAccess && autoAdvance; // R2

    rpc_pointer pointer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .loadUpper(wrHigh),
        .loadLower(wrLow),
        .loadData(regBus.wrData),
        .advance(advance),
        .pointer(ramAddr)
    );

    ////////////////////////////////////////////////////////////////////////
    // control bits; software reset does not touch any of them
    always_comb
    begin
        next_readDirection = readDirection;
        next_autoAdvance = autoAdvance;
        next_selTop = indirectSelect[rpc_pkg::SEL_TOP];
        next_selLow = indirectSelect[rpc_pkg::SEL_LOW_MSB:0];
        next_softReset = softReset;
        next_chaining = chainingEnable;
        next_txEnBit = transmitEnableBit;
        if (wrHigh)
        begin
            next_readDirection = regBus.wrData[rpc_pkg::PH_READ_DIR]; // R1
            next_autoAdvance = regBus.wrData[rpc_pkg::PH_AUTO]; // R2
        end
        if (wrSel)
        begin
            next_selTop = regBus.wrData[rpc_pkg::SEL_TOP]; // R5
            next_selLow = regBus.wrData[rpc_pkg::SEL_LOW_MSB:0]; // R6
        end
        // config write owns the low select bits
        if (wrCfg)
        begin
            next_selTop = 1'b0; // R7
            next_selLow = regBus.wrData[rpc_pkg::SEL_LOW_MSB:0]; // R6
            next_softReset = regBus.wrData[rpc_pkg::CFG_SW_RESET]; // R8 R11
            next_chaining = regBus.wrData[rpc_pkg::CFG_CHAIN]; // R12
            next_txEnBit = regBus.wrData[rpc_pkg::CFG_TX_ENABLE]; // R14
        end
        // flag tracks the value being stored
        next_selectReserved = {next_selTop, next_selLow} > rpc_pkg::IND_SETUP2; // R5
    end

    // transmit drivers gated by the enable bit, pulse b free in backplane mode
    // outputs idle high, one cycle behind requests
    always_comb
    begin
        next_driverEnable_n = !(transmitEnableBit && txDriveReq); // R13 R14
        next_linePulseA_n = !(transmitEnableBit && pulseAReq); // R13 R14
        next_linePulseB_n = !((transmitEnableBit || backplaneMode) && pulseBReq); // R13
    end

    // state registers; only rst_n clears them
    // software reset is exported, never applied here
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            readDirection <= rpc_pkg::RST_FLAG;
            autoAdvance <= rpc_pkg::RST_FLAG;
            indirectSelect <= rpc_pkg::RST_SEL;
            selectReserved <= rpc_pkg::RST_FLAG;
            softReset <= rpc_pkg::RST_FLAG;
            chainingEnable <= rpc_pkg::RST_FLAG;
            transmitEnableBit <= rpc_pkg::RST_FLAG; // R15
            driverEnable_n <= 1'b1;
            linePulseA_n <= 1'b1;
            linePulseB_n <= 1'b1;
        end
        else
        begin
            readDirection <= next_readDirection;
            autoAdvance <= next_autoAdvance;
            indirectSelect <= {next_selTop, next_selLow};
            selectReserved <= next_selectReserved;
            softReset <= next_softReset; // R9 R10
            chainingEnable <= next_chaining;
            transmitEnableBit <= next_txEnBit;
            driverEnable_n <= next_driverEnable_n;
            linePulseA_n <= next_linePulseA_n;
            linePulseB_n <= next_linePulseB_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // all properties sample on sys_clk
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_stepAtTop;
        (ramAddr == rpc_pkg::PTR_TOP) && advance && !wrHigh && !wrLow;
    endsequence

    sequence s_plainStep;
        advance && !wrHigh && !wrLow;
    endsequence

    sequence s_cfgWrite;
        wrCfg && !wrSel;
    endsequence

    // pointer checks
    a_dir_follows_write: assert property (wrHigh |=> readDirection == $past(regBus.wrData[7])) // R1
        else $error("direction bit not loaded");
    a_pointer_step: assert property (s_plainStep |=> ramAddr == $past(ramAddr) + 11'h001) // R2
        else $error("pointer did not advance");
    a_pointer_holds: assert property (!advance && !wrHigh && !wrLow |=> $stable(ramAddr)) // R2
        else $error("pointer moved without cause");
    a_upper_bits: assert property (wrHigh |=> ramAddr[10:8] == $past(regBus.wrData[2:0])) // R3
        else $error("upper pointer bits wrong");
    a_lower_bits: assert property (wrLow |=> ramAddr[7:0] == $past(regBus.wrData)) // R4
        else $error("lower pointer bits wrong");

    // select checks
    a_select_reserved: assert property (selectReserved == (indirectSelect > 3'h4)) // R5
        else $error("reserved select flag wrong");
    a_select_load: assert property (wrSel && !wrCfg |=> indirectSelect == $past(regBus.wrData[2:0])) // R5
        else $error("select not loaded");
    a_cfg_shared_low: assert property (s_cfgWrite |=> indirectSelect[1:0] == $past(regBus.wrData[1:0])) // R6
        else $error("shared select bits not loaded");
    a_cfg_clears_top: assert property (s_cfgWrite |=> !indirectSelect[2]) // R7
        else $error("top select bit not cleared");

    // configuration checks
    a_soft_reset: assert property (wrCfg |=> softReset == $past(regBus.wrData[7])) // R8
        else $error("software reset bit not loaded");
    a_reset_keeps_cfg: assert property (softReset && !wrCfg ##1 !wrCfg |-> $stable(chainingEnable) // R9
        && $stable(transmitEnableBit) && $stable(softReset))
        else $error("software reset changed configuration");
    a_reset_keeps_ptr: assert property (softReset && !advance && !wrHigh && !wrLow |=> $stable(ramAddr)) // R10
        else $error("software reset moved pointer");
    a_chaining_bit: assert property (wrCfg |=> chainingEnable == $past(regBus.wrData[6])) // R12
        else $error("chaining bit not loaded");

    // driver checks and pointer wrap
    a_tx_gated: assert property (!transmitEnableBit |=> driverEnable_n && linePulseA_n) // R13
        else $error("driver active while transmit disabled");
    a_pulse_b_gated: assert property (!transmitEnableBit && !backplaneMode |=> linePulseB_n) // R13
        else $error("pulse b active while disabled");
    a_tx_passes: assert property (transmitEnableBit && txDriveReq |=> !driverEnable_n) // R14
        else $error("driver enable blocked");
    a_pulse_a_passes: assert property (transmitEnableBit && pulseAReq |=> !linePulseA_n) // R14
        else $error("pulse a blocked");
    a_pulse_b_passes: assert property ((transmitEnableBit || backplaneMode) && pulseBReq |=> !linePulseB_n) // R14
        else $error("pulse b blocked");
    a_tx_enable_reset: assert property (@(posedge sys_clk) disable iff (1'b0) !rst_n |=> !transmitEnableBit) // R15
        else $error("transmit enable not cleared by reset");
    a_pointer_wrap: assert property (s_stepAtTop |=> ramAddr == 11'h000) // R17
        else $error("pointer did not wrap");
endmodule // rpc_regs_top
`default_nettype wire
